// >>> rtl/ssr_top.sv
// dual serial port, synchronous slave receive path, on an apb slave.
// assumes pclk at 200 MHz, link clocks well below it, pins raw from pads.
`timescale 1ns/1ps
`include "ssr_consts.svh"
// Notes on behaviour
// - port drives a pin per mode only when its direction bit is clear
// - pins belong to port only when enabled
// - slave needs direction bits set to input
// - slave ignores single receive enable
// - continuous receive keeps running in sleep
// - unmasked receive wakes chip, vectors if enabled
// - slave mode: sync, enable, external clock
// - nine-bit words put ninth bit in status
// - word sets complete flag and interrupt
// - low eight bits readable in data register
// - overrun reported, framing bit reads 0; clearing receive clears overrun
// - two independent port instances
// - sync modes with selectable clock polarity
// - async break, wake on reception
module ssr_top
  import ssr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] ck_in,
  output logic [1:0] ck_out,
  output logic [1:0] ck_oe,
  input wire logic [1:0] dt_in,
  output logic [1:0] dt_out,
  output logic [1:0] dt_oe,
  input wire logic low_power,
  output logic wake,
  output logic irq
);
  // ==========================================
  // register storage, one entry per port, then shared interrupt and read state
  logic [7:0] rcsta_ff [2]; // writable receive control bits
  logic [7:0] txsta_ff [2]; // writable transmit control bits
  logic [7:0] baud_ff [2]; // writable baud control bits
  logic [7:0] divh_ff [2]; // divisor high byte
  logic [7:0] brgl_ff [2]; // divisor low byte
  logic [7:0] pdir_ff [2]; // pin direction, 1 = input
  logic [7:0] rcreg_ff [2]; // received data
  logic [1:0] full_ff; // data register holds unread word
  logic [1:0] ovr_ff; // overrun seen
  logic [1:0] bit8_ff; // ninth bit of last word
  logic [7:0] intctl_ff; // global and peripheral enables
  logic [5:0] istat_ff; // sticky events
  logic [5:0] imask_ff; // event enables
  logic [31:0] nxt_prdata; // read mux
  logic nxt_err; // unmapped address
  // per-port decode and channel wiring
  ssr_mode_e mode [2];
  logic [1:0] rx_on, done, idle, brk_busy, wake_seen, rd_data, brk_go;
  ssr_word_t word [2];
  // bus decode
  logic setup_ph, access_ph, wr_acc, rd_acc, port_hit, glob_hit;
  logic [4:0] off;
  logic port;

  // ==========================================
  // apb decode
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_acc = access_ph & pwrite;
  assign rd_acc = access_ph & ~pwrite;
  assign off = paddr[4:0];
  assign port = paddr[5];
  assign port_hit = (paddr[11:6] == 6'h00);
  assign glob_hit = (paddr[11:5] == `SSR_PAGE_GLOBAL);
  // zero wait state: read data is captured during setup
  assign pready = 1'b1;

  // ==========================================
  // mode decode and channels
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_port
      // sync + enable, clock source clear = slave
      always_comb
      begin
        if (!rcsta_ff[g][`SSR_RC_PORT_EN])
          mode[g] = ssr_off;
        else if (!txsta_ff[g][`SSR_TX_SYNC])
          mode[g] = ssr_async;
        else if (txsta_ff[g][`SSR_TX_CLK_SRC])
          mode[g] = ssr_master;
        else
          mode[g] = ssr_slave;
      end
      // both pins must be configured as inputs
      // low_power deliberately does not gate this
      assign rx_on[g] = (mode[g] == ssr_slave) & rcsta_ff[g][`SSR_RC_CONT] & ~ovr_ff[g]
                        & pdir_ff[g][`SSR_PD_CK] & pdir_ff[g][`SSR_PD_DT];
      assign rd_data[g] = rd_acc & port_hit & (port == g[0]) & (off == `SSR_OFF_RCREG);
      assign brk_go[g] = wr_acc & port_hit & (port == g[0]) & (off == `SSR_OFF_TXSTA)
                         & pwdata[`SSR_TX_BREAK];
      // direction follows mode, master drives clock, async drives tx
      // nothing is driven while the port is off
      assign ck_oe[g] = ~pdir_ff[g][`SSR_PD_CK] & ((mode[g] == ssr_master)
                        | ((mode[g] == ssr_async) & txsta_ff[g][`SSR_TX_XMIT_EN]));
      // master clock idles at the selected polarity
      assign ck_out[g] = (mode[g] == ssr_master) ? baud_ff[g][`SSR_BD_CK_POL] : ~brk_busy[g];
      // receive-only path never drives data
      assign dt_oe[g] = 1'b0;
      assign dt_out[g] = 1'b0;
      ssr_chan u_chan (
        .pclk(pclk),
        .presetn(presetn),
        .ck_pin(ck_in[g]),
        .dt_pin(dt_in[g]),
        .mode(mode[g]),
        .rx_on(rx_on[g]),
        .nine_bit(rcsta_ff[g][`SSR_RC_NINE]),
        .ck_pol(baud_ff[g][`SSR_BD_CK_POL]),
        .dt_inv(baud_ff[g][`SSR_BD_DT_INV]),
        .wake_en(baud_ff[g][`SSR_BD_WAKE_EN]),
        .brk_go(brk_go[g]),
        .divisor(baud_ff[g][`SSR_BD_DIV16] ? {divh_ff[g], brgl_ff[g]} : {8'h00, brgl_ff[g]}),
        .word_done(done[g]),
        .word_data(word[g]),
        .rx_idle(idle[g]),
        .brk_busy(brk_busy[g]),
        .wake_seen(wake_seen[g])
      );
    end
  endgenerate

  // ==========================================
  // control register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int p = 0; p < 2; p++)
      begin
        rcsta_ff[p] <= `SSR_RST_REG;
        txsta_ff[p] <= `SSR_RST_REG;
        baud_ff[p] <= `SSR_RST_REG;
        divh_ff[p] <= `SSR_RST_REG;
        brgl_ff[p] <= `SSR_RST_REG;
        pdir_ff[p] <= `SSR_RST_PDIR;
      end
    end
    else
    begin
      for (int p = 0; p < 2; p++)
      begin
        // wake enable drops once the wake edge has been seen
        if (wake_seen[p])
          baud_ff[p][`SSR_BD_WAKE_EN] <= 1'b0;
        if (wr_acc && port_hit && port == p[0])
        begin
          unique case (off)
            `SSR_OFF_RCSTA: rcsta_ff[p] <= pwdata[7:0] & `SSR_RC_WMASK;
            `SSR_OFF_TXSTA: txsta_ff[p] <= pwdata[7:0] & `SSR_TX_WMASK & ~8'h08;
            `SSR_OFF_BAUD: baud_ff[p] <= pwdata[7:0] & `SSR_BD_WMASK;
            `SSR_OFF_DIVH: divh_ff[p] <= pwdata[7:0];
            `SSR_OFF_BRGL: brgl_ff[p] <= pwdata[7:0];
            `SSR_OFF_PDIR: pdir_ff[p] <= pwdata[7:0] & `SSR_RST_PDIR;
            default: ;
          endcase
        end
      end
    end
  end

  // ==========================================
  // receive data path and error flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      full_ff <= 2'h0;
      ovr_ff <= 2'h0;
      bit8_ff <= 2'h0;
      rcreg_ff[0] <= 8'h00;
      rcreg_ff[1] <= 8'h00;
    end
    else
    begin
      for (int p = 0; p < 2; p++)
      begin
        if (!rcsta_ff[p][`SSR_RC_CONT])
          ovr_ff[p] <= 1'b0;
        // a word into a full register is lost
        else if (done[p] && full_ff[p])
          ovr_ff[p] <= 1'b1;
        if (done[p] && !full_ff[p])
        begin
          rcreg_ff[p] <= word[p][7:0];
          bit8_ff[p] <= word[p][8];
          full_ff[p] <= 1'b1;
        end
        // a word landing in the very cycle of the read still counts as overrun
        else if (rd_data[p])
          full_ff[p] <= 1'b0;
      end
    end
  end

  // ==========================================
  // interrupt control and sticky status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      intctl_ff <= `SSR_RST_REG;
      imask_ff <= 6'h00;
      istat_ff <= 6'h00;
    end
    else
    begin
      if (wr_acc && glob_hit && off == `SSR_OFF_INTCTL)
        intctl_ff <= pwdata[7:0] & 8'hC0;
      if (wr_acc && glob_hit && off == `SSR_OFF_IMASK)
        imask_ff <= pwdata[5:0];
      // events set flags; a set in the clearing cycle wins
      istat_ff <= (istat_ff & ~((wr_acc && glob_hit && off == `SSR_OFF_ISTAT) ? pwdata[5:0] : 6'h00))
                  | {wake_seen, done & full_ff, done & ~full_ff};
    end
  end

  // wake needs the mask and low_power; the line needs the mask and both enables
  // global and peripheral enables gate the line
  assign wake = low_power & |(istat_ff & imask_ff);
  assign irq = intctl_ff[`SSR_INT_GLOBAL] & intctl_ff[`SSR_INT_PERIPH] & |(istat_ff & imask_ff);

  // ==========================================
  // read mux, captured in setup so data comes from a flop
  always_comb
  begin
    nxt_prdata = 32'h00000000;
    nxt_err = 1'b0;
    if (port_hit)
    begin
      unique case (off)
        `SSR_OFF_RCSTA: nxt_prdata[7:0] = rcsta_ff[port] | {5'h00, 1'b0, ovr_ff[port], bit8_ff[port]};
        `SSR_OFF_RCREG: nxt_prdata[7:0] = rcreg_ff[port];
        `SSR_OFF_TXSTA: nxt_prdata[7:0] = txsta_ff[port] | {6'h00, ~brk_busy[port], 1'b0};
        `SSR_OFF_BAUD: nxt_prdata[7:0] = baud_ff[port] | {1'b0, idle[port], 6'h00};
        `SSR_OFF_DIVH: nxt_prdata[7:0] = divh_ff[port];
        `SSR_OFF_BRGL: nxt_prdata[7:0] = brgl_ff[port];
        `SSR_OFF_PDIR: nxt_prdata[7:0] = pdir_ff[port];
        default: nxt_err = 1'b1;
      endcase
    end
    else if (glob_hit)
    begin
      unique case (off)
        `SSR_OFF_INTCTL: nxt_prdata[7:0] = intctl_ff;
        `SSR_OFF_ISTAT: nxt_prdata[5:0] = istat_ff;
        `SSR_OFF_IMASK: nxt_prdata[5:0] = imask_ff;
        default: nxt_err = 1'b1;
      endcase
    end
    else
      nxt_err = 1'b1;
  end

  // bus answer flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata <= pwrite ? 32'h00000000 : nxt_prdata;
      pslverr <= nxt_err;
    end
  end

  // ==========================================
  // checks, one set per port, then one shared wake check
  generate
    for (g = 0; g < 2; g++)
    begin : g_chk
      sequence accept_s;
        done[g] && !full_ff[g];
      endsequence
      // accepted word lands in data register
      rx_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        accept_s |=> full_ff[g] && rcreg_ff[g] == $past(word[g][7:0]))
        else $error("received byte not loaded");
      // ninth bit captured with the word
      ninth_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        accept_s ##1 rcsta_ff[g][`SSR_RC_NINE] |-> bit8_ff[g] == $past(word[g][8]))
        else $error("ninth bit not captured");
      // complete flag follows an accepted word
      rx_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        accept_s |=> istat_ff[`SSR_IS_RXC + g])
        else $error("receive flag not set");
      overrun_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        done[g] && full_ff[g] && rcsta_ff[g][`SSR_RC_CONT] |=> ovr_ff[g] && istat_ff[`SSR_IS_OVR + g])
        else $error("overrun not flagged");
      err_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        !rcsta_ff[g][`SSR_RC_CONT] |=> !ovr_ff[g])
        else $error("overrun survived receive disable");
      pins_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !rcsta_ff[g][`SSR_RC_PORT_EN] |-> !ck_oe[g] && !dt_oe[g])
        else $error("pin driven while port disabled");
      // slave keeps both pins as inputs
      slave_in_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode[g] == ssr_slave |-> !ck_oe[g] && !dt_oe[g])
        else $error("slave mode drives a pin");
      // single receive enable has no say in slave
      single_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode[g] == ssr_slave && rcsta_ff[g][`SSR_RC_CONT] && !ovr_ff[g] && pdir_ff[g][1:0] == 2'h3
        |-> rx_on[g])
        else $error("slave receive not running");
    end
  endgenerate

  // unmasked pending event in sleep asserts wake
  wake_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    low_power && |(istat_ff & imask_ff) |-> wake && (irq == (intctl_ff[7:6] == 2'h3)))
    else $error("wake or vector gating wrong");
endmodule : ssr_top

// >>> rtl/ssr_consts.svh
// register map, field positions, reset values and timing counts of the
// dual serial port receiver; included by the top and channel modules and the bench.
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH
// ==========================================
// address map (byte addresses, one word per register)
`define SSR_PAGE_GLOBAL 7'h02
`define SSR_OFF_RCSTA 5'h00
`define SSR_OFF_RCREG 5'h04
`define SSR_OFF_TXSTA 5'h08
`define SSR_OFF_BAUD 5'h0C
`define SSR_OFF_DIVH 5'h10
`define SSR_OFF_BRGL 5'h14
`define SSR_OFF_PDIR 5'h18
`define SSR_OFF_INTCTL 5'h00
`define SSR_OFF_ISTAT 5'h04
`define SSR_OFF_IMASK 5'h08
// ==========================================
// receive status and control fields
`define SSR_RC_PORT_EN 7
`define SSR_RC_NINE 6
`define SSR_RC_SINGLE 5
`define SSR_RC_CONT 4
`define SSR_RC_FRAME 2
`define SSR_RC_OVER 1
`define SSR_RC_BIT8 0
`define SSR_RC_WMASK 8'hF8
// transmit status and control fields
`define SSR_TX_CLK_SRC 7
`define SSR_TX_XMIT_EN 5
`define SSR_TX_SYNC 4
`define SSR_TX_BREAK 3
`define SSR_TX_EMPTY 1
`define SSR_TX_WMASK 8'hFD
// baud control fields
`define SSR_BD_IDLE 6
`define SSR_BD_DT_INV 5
`define SSR_BD_CK_POL 4
`define SSR_BD_DIV16 3
`define SSR_BD_WAKE_EN 1
`define SSR_BD_WMASK 8'hBB
// pin direction fields (1 = input)
`define SSR_PD_CK 0
`define SSR_PD_DT 1
// interrupt control and status fields
`define SSR_INT_GLOBAL 7
`define SSR_INT_PERIPH 6
`define SSR_IS_RXC 0
`define SSR_IS_OVR 2
`define SSR_IS_WAKE 4
// ==========================================
// reset values and timing
`define SSR_RST_REG 8'h00
`define SSR_RST_PDIR 8'h03
`define SSR_BREAK_BITS 4'hC
`endif

// >>> rtl/ssr_pkg.sv
// shared types of the dual serial port receiver.
// assumes nothing beyond a SystemVerilog compiler.
package ssr_pkg;
  // ==========================================
  // operating mode of one port
  typedef enum logic [1:0] {
    ssr_off = 2'b00,
    ssr_async = 2'b01,
    ssr_master = 2'b10,
    ssr_slave = 2'b11
  } ssr_mode_e;
  // one received word, ninth bit on top
  typedef logic [8:0] ssr_word_t;
endpackage : ssr_pkg

// >>> rtl/ssr_chan.sv
// one serial port channel: link sampling, shift register, break timer.
// assumes pins are raw (unsynchronised) and config comes from pclk logic.
`timescale 1ns/1ps
`include "ssr_consts.svh"
module ssr_chan
  import ssr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ck_pin,
  input wire logic dt_pin,
  input wire ssr_mode_e mode,
  input wire logic rx_on,
  input wire logic nine_bit,
  input wire logic ck_pol,
  input wire logic dt_inv,
  input wire logic wake_en,
  input wire logic brk_go,
  input wire logic [15:0] divisor,
  output logic word_done,
  output ssr_word_t word_data,
  output logic rx_idle,
  output logic brk_busy,
  output logic wake_seen
);
  // ==========================================
  // pin synchronisers
  logic ck_s1_ff, ck_s2_ff, ck_s3_ff;
  logic dt_s1_ff, dt_s2_ff, dt_s3_ff;
  logic [3:0] bit_cnt_ff;
  ssr_word_t shreg_ff;
  logic [15:0] div_cnt_ff;
  logic [3:0] brk_cnt_ff;
  logic ck_edge, last_bit, dbit, tick;
  ssr_word_t nxt_shreg;

  // two flops per pin, third flop only for edge finding
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {ck_s1_ff, ck_s2_ff, ck_s3_ff} <= 3'h0;
      {dt_s1_ff, dt_s2_ff, dt_s3_ff} <= 3'h7;
    end
    else
    begin
      {ck_s1_ff, ck_s2_ff, ck_s3_ff} <= {ck_pin, ck_s1_ff, ck_s2_ff};
      {dt_s1_ff, dt_s2_ff, dt_s3_ff} <= {dt_pin, dt_s1_ff, dt_s2_ff};
    end
  end

  // ==========================================
  // shift register
  // sample edge follows polarity
  assign ck_edge = ck_pol ? (ck_s3_ff & ~ck_s2_ff) : (~ck_s3_ff & ck_s2_ff);
  assign dbit = dt_s2_ff ^ dt_inv;
  assign last_bit = (bit_cnt_ff == (nine_bit ? 4'h8 : 4'h7));
  assign nxt_shreg = {dbit, shreg_ff[8:1]};
  assign rx_idle = (bit_cnt_ff == 4'h0);

  // one sample per link clock period; disabling drops a partial word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_cnt_ff <= 4'h0;
      shreg_ff <= 9'h000;
    end
    else if (!rx_on)
      bit_cnt_ff <= 4'h0;
    else if (ck_edge)
    begin
      shreg_ff <= nxt_shreg;
      bit_cnt_ff <= last_bit ? 4'h0 : bit_cnt_ff + 4'h1;
    end
  end

  // eight-bit words sit one place higher in the shift register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      word_done <= 1'b0;
      word_data <= 9'h000;
    end
    else
    begin
      word_done <= rx_on & ck_edge & last_bit;
      if (rx_on & ck_edge & last_bit)
        word_data <= nine_bit ? nxt_shreg : {1'b0, nxt_shreg[8:1]};
    end
  end

  // ==========================================
  // break timer and wake detect (async only)
  assign tick = (div_cnt_ff == divisor);
  assign brk_busy = (brk_cnt_ff != 4'h0);

  // twelve bit times of low line
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt_ff <= 16'h0000;
      brk_cnt_ff <= 4'h0;
    end
    else
    begin
      div_cnt_ff <= tick ? 16'h0000 : div_cnt_ff + 16'h0001;
      if (brk_go && mode == ssr_async && !brk_busy)
        brk_cnt_ff <= `SSR_BREAK_BITS;
      else if (tick && brk_busy)
        brk_cnt_ff <= brk_cnt_ff - 4'h1;
    end
  end

  // falling receive line wakes in async
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wake_seen <= 1'b0;
    else
      wake_seen <= wake_en & (mode == ssr_async) & dt_s3_ff & ~dt_s2_ff;
  end

  sequence brk_start_s;
    brk_go && mode == ssr_async && !brk_busy;
  endsequence
  brk_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    brk_start_s |=> brk_busy && brk_cnt_ff == `SSR_BREAK_BITS)
    else $error("break did not start");
  // a word needs the receiver on
  word_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    word_done |-> $past(rx_on) && $past(rx_idle) == 1'b0)
    else $error("word completed without receiver");
endmodule : ssr_chan

// >>> sim/ssr_master_model.sv
// external synchronous master: drives one port's clock and data pins.
// assumes the receiver samples lsb first on the edge its polarity picks.
`timescale 1ns/1ps
module ssr_master_model
(
  output logic ck,
  output logic dt
);
  // ==========================================
  // power-up idle levels
  initial
  begin
    ck = 1'b0;
    dt = 1'b0;
  end
  // ==========================================
  // one frame; the clock stands still between frames
  task automatic send(input logic [8:0] w, input int n, input logic pol, input logic inv, input realtime h);
    // odd offset keeps link edges off the pclk grid
    #0.7;
    ck = pol;
    #(h);
    for (int i = 0; i < n; i++)
    begin
      dt = w[i] ^ inv;
      #(h);
      ck = ~pol;
      #(h);
      ck = pol;
    end
    // released line never repeats the last bit
    dt = ~dt;
  endtask : send
endmodule : ssr_master_model

// >>> sim/test_sync_serial_slave_receiver.sv
// self-checking bench of the dual serial port receiver.
// assumes ssr_top with its apb map and two link masters.
`timescale 1ns/1ps
`include "ssr_consts.svh"
module test_sync_serial_slave_receiver;
  // ==========================================
  // stimulus, model state and counters
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, low_power = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, wake, err, line_en = 1'b0, nine;
  logic [1:0] ck_out, ck_oe, dt_out, dt_oe;
  wire [1:0] ck_in, dt_in;
  int miscompares = 0, n_compared = 0, seed = 41469, p;
  logic [8:0] exp_data [2] = '{9'h000, 9'h000};
  logic [7:0] exp_cfg [2] = '{8'h00, 8'h00};
  logic exp_full [2] = '{1'b0, 1'b0};
  logic exp_ovr [2] = '{1'b0, 1'b0};
  logic [7:0] exp_ist = 8'h00, exp_msk = 8'h00;
  localparam logic [11:0] A_INT = {`SSR_PAGE_GLOBAL, `SSR_OFF_INTCTL};
  localparam logic [11:0] A_IST = {`SSR_PAGE_GLOBAL, `SSR_OFF_ISTAT};
  localparam logic [11:0] A_MSK = {`SSR_PAGE_GLOBAL, `SSR_OFF_IMASK};
  logic [4:0] rs_off [5] = '{`SSR_OFF_RCSTA, `SSR_OFF_RCREG, `SSR_OFF_TXSTA, `SSR_OFF_PDIR, 5'h1C};
  // an idle transmitter reads back with its shift-empty bit set
  logic [7:0] rs_val [5] = '{`SSR_RST_REG, `SSR_RST_REG, 8'h02, `SSR_RST_PDIR, 8'h00};
  always #2.5 pclk = ~pclk;
  ssr_master_model mdl0 (.ck(ck_in[0]), .dt(dt_in[0]));
  ssr_master_model mdl1 (.ck(ck_in[1]), .dt(dt_in[1]));
  ssr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ck_in(ck_in), .ck_out(ck_out), .ck_oe(ck_oe), .dt_in(dt_in), .dt_out(dt_out), .dt_oe(dt_oe),
    .low_power(low_power), .wake(wake), .irq(irq));
  // ==========================================
  // compares
  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  task chk_pin(input logic got, input logic exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask : chk_pin
  function automatic logic [11:0] ra(input int q, input logic [4:0] off);
    return 12'(q * 32) + {7'h00, off};
  endfunction : ra
  // ==========================================
  // apb master: holds the request until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // a slave that never answers ends the run
    if (n >= 20)
    begin
      miscompares++;
      finish_test;
    end
  endtask : apb
  task cfg(input int q, input logic [7:0] v);
    apb(1'b1, ra(q, `SSR_OFF_RCSTA), {24'h0, v});
    exp_cfg[q] = v & 8'hF8;
    if (!v[4])
      exp_ovr[q] = 1'b0;
  endtask : cfg
  // status, control bits and both level outputs against the model
  task check(input int q, input logic nb);
    apb(1'b0, A_IST, 32'h0);
    chk_reg(rd, {24'h0, exp_ist});
    apb(1'b0, ra(q, `SSR_OFF_RCSTA), 32'h0);
    chk_reg(rd & (nb ? 32'hFF : 32'hFE),
      {24'h0, exp_cfg[q] | 8'(exp_ovr[q]) << 1 | 8'(nb & exp_data[q][8])});
    chk_pin(irq, line_en && |(exp_ist & exp_msk));
    chk_pin(wake, low_power && |(exp_ist & exp_msk));
  endtask : check
  // one word over the link; full register means overrun, overrun stops the receiver
  task word(input int q, input logic nb, input logic pol, input logic inv, input realtime h);
    logic [8:0] w;
    w = 9'($random(seed));
    if (q == 0)
      mdl0.send(w, nb ? 9 : 8, pol, inv, h);
    else
      mdl1.send(w, nb ? 9 : 8, pol, inv, h);
    repeat (6) @(posedge pclk);
    if (!exp_ovr[q] && exp_full[q])
    begin
      exp_ovr[q] = 1'b1;
      exp_ist |= 8'h04 << q;
    end
    else if (!exp_ovr[q])
    begin
      exp_data[q] = nb ? w : {1'b0, w[7:0]};
      exp_full[q] = 1'b1;
      exp_ist |= 8'h01 << q;
    end
    check(q, nb);
  endtask : word
  task take(input int q);
    apb(1'b0, ra(q, `SSR_OFF_RCREG), 32'h0);
    chk_reg(rd, {24'h0, exp_data[q][7:0]});
    exp_full[q] = 1'b0;
  endtask : take
  task finish_test;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // ==========================================
  // watchdog: the run needs well under a third of this
  initial
  begin
    #100us;
    miscompares++;
    finish_test;
  end
  // ==========================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // both ports reset alike, unmapped slot refused
    for (int q = 0; q < 10; q++)
    begin
      apb(1'b0, ra(q / 5, rs_off[q % 5]), 32'h0);
      chk_reg(rd, {24'h0, rs_val[q % 5]});
      chk_pin(err, q % 5 == 4);
    end
    chk_pin(irq | (|ck_oe) | (|dt_oe) | (|dt_out), 1'b0);
    $display("test reset done");
    // master drives the clock pin only while enabled
    apb(1'b1, ra(0, `SSR_OFF_TXSTA), 32'h90);
    cfg(0, 8'h80);
    apb(1'b1, ra(0, `SSR_OFF_PDIR), 32'h0);
    @(negedge pclk);
    chk_pin(ck_oe[0], 1'b1);
    chk_pin(ck_out[0], 1'b0);
    cfg(0, 8'h00);
    @(negedge pclk);
    chk_pin(ck_oe[0], 1'b0);
    // slave: sync set, clock source clear, pins input
    for (int q = 0; q < 2; q++)
    begin
      apb(1'b1, ra(q, `SSR_OFF_PDIR), 32'h3);
      apb(1'b1, ra(q, `SSR_OFF_TXSTA), 32'h10);
    end
    // software sets global and peripheral enables
    apb(1'b1, A_INT, 32'hC0);
    line_en = 1'b1;
    apb(1'b1, A_MSK, 32'h03);
    exp_msk = 8'h03;
    $display("test pins done");
    // single receive set but ignored; sleep from i=4
    for (int i = 0; i < 8; i++)
    begin
      p = i % 2;
      nine = i[2];
      apb(1'b1, ra(p, `SSR_OFF_BAUD), {26'h0, i[1] ^ i[2], i[1], 4'h0});
      cfg(p, {1'b1, nine, 6'h30});
      low_power <= i[2];
      @(negedge pclk);
      chk_pin(ck_oe[p] | dt_oe[p], 1'b0);
      word(p, nine, i[1], i[1] ^ i[2], 80.0);
      take(p);
      apb(1'b1, A_IST, 32'h1 << p);
      exp_ist &= ~(8'h01 << p);
      check(p, nine);
    end
    $display("test receive done");
    // overrun on port 1 with only overrun unmasked
    low_power <= 1'b0;
    apb(1'b1, ra(1, `SSR_OFF_BAUD), 32'h0);
    cfg(1, 8'h90);
    apb(1'b1, A_MSK, 32'h0C);
    exp_msk = 8'h0C;
    for (int k = 0; k < 3; k++)
      word(1, 1'b0, 1'b0, 1'b0, 80.0);
    apb(1'b1, A_INT, 32'h40);
    line_en = 1'b0;
    low_power <= 1'b1;
    check(1, 1'b0);
    cfg(1, 8'h80);
    check(1, 1'b0);
    take(1);
    $display("test overrun done");
    apb(1'b1, ra(1, `SSR_OFF_TXSTA), 32'h0);
    apb(1'b1, ra(1, `SSR_OFF_TXSTA), 32'h08);
    apb(1'b0, ra(1, `SSR_OFF_TXSTA), 32'h0);
    chk_reg(rd, 32'h0);
    repeat (20) @(posedge pclk);
    apb(1'b0, ra(1, `SSR_OFF_TXSTA), 32'h0);
    chk_reg(rd, 32'h2);
    $display("test break done");
    finish_test;
  end
endmodule : test_sync_serial_slave_receiver
